// ==== dma_read_cmd.sv ====
// dma read command decoder: command block, sector sequencing, dma handoff, status and interrupt
// Overview of operation
// - 28-bit device/head low nibble is head in CHS, address bits 24-27 in LBA.
// - lowest opcode bit of the 28-bit read is ignored.
// - 28-bit completion leaves count of untransferred sectors, zero unless error.
// - 28-bit completion reports last transferred sector address across the four registers.
// - opcode 25h starts a 48-bit dma read from media to host.
// - 48-bit read data moves as 16-bit words.
// - each word is qualified by the dma request and taken by host dma.
// - exactly one interrupt per read, after transfer ends and status is final.
// - uncorrectable media error stops the transfer at the failing sector.
// - 48-bit count: current byte is bits 7:0, previous byte bits 15:8.
// - 48-bit count of zero means 65,536 sectors.
// - 48-bit start address assembled from current and previous address bytes.
// - failed 48-bit read presents first error address, upper bytes under high-order select.
// - opcode 60h starts a queued first-party dma read.
// - error register shows crc, unc, idnf, abort in 7,6,4,2; others zero.
// - status shows busy, fault, corrected clear; ready, seek-complete, error valid.
// - 28-bit count of zero means 256 sectors.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dma_read_cmd
	import rdcmd_pkg::*;
#(
	parameter int          WORDS_PER_SEC = 256,
	parameter logic [7:0]  CHS_SPT       = 8'h3f,
	parameter logic [3:0]  CHS_HEADS     = 4'hf
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	// register port
	input  wire logic [3:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	// media engine
	output logic                       med_req,
	output rdcmd_pkg::med_req_type     med_cmd,
	input  wire logic                  med_valid,
	output logic                       med_ready,
	input  wire logic [15:0]           med_data,
	input  wire logic                  med_last,
	input  wire logic                  med_unc,
	input  wire logic                  med_idnf,
	// host dma
	output logic                       dmarq,
	input  wire logic                  dma_ack,
	output logic [15:0]                dma_data,
	input  wire logic                  crc_err,
	// interrupt
	output logic                       irq
);
	import rdcmd_pkg::*;

	state_type    state_ff;
	state_type    nxt_state;
	tf_pair_type  feat_ff;
	tf_pair_type  scnt_ff;
	tf_pair_type  snum_ff;
	tf_pair_type  cyllo_ff;
	tf_pair_type  cylhi_ff;
	logic [7:0]   devhead_ff;
	logic         hob_ff;
	logic         ext_ff;
	logic         chs_ff;
	logic [47:0]  addr_ff;
	logic [47:0]  last_ff;
	logic [16:0]  remain_ff;
	logic [7:0]   err_ff;
	logic [15:0]  word_ff;
	logic         full_ff;
	logic         lastw_ff;
	logic [1:0]   int_stat_ff;
	logic [1:0]   int_mask_ff;
	logic [7:0]   rdata_ff;

	logic         busy;
	logic         cmd_wr;
	logic         is_rd28;
	logic         is_rd48;
	logic         is_rdq;
	logic         take_word;
	logic         sec_done;
	logic         med_fail;
	logic         fail_any;
	logic [47:0]  rep_addr;
	logic [16:0]  cnt_start;
	logic [47:0]  addr_start;
	logic [7:0]   status;

	// next sector address; CHS layout is sector [7:0], cylinder [23:8], head [27:24]
	function automatic logic [47:0] next_addr(input logic [47:0] a, input logic chs);
		logic [47:0] r;
		r = a + 48'h1;
		if (chs) begin
			r = a;
			if (a[7:0] == CHS_SPT) begin
				r[7:0] = FIRST_SEC;
				if (a[27:24] == CHS_HEADS) begin
					r[27:24] = 4'h0;
					r[23:8]  = a[23:8] + 16'h1;
				end else begin
					r[27:24] = a[27:24] + 4'h1;
				end
			end else begin
				r[7:0] = a[7:0] + 8'h1;
			end
		end
		return r;
	endfunction

	assign busy   = (state_ff != ST_IDLE);
	assign cmd_wr = reg_wr && (reg_addr == ADR_CMD_STAT) && !busy;
	// retry bit ignored
	// match bits 7:1
	assign is_rd28 = (reg_wdata[7:1] == OPC_READ28_HI);
	assign is_rd48 = (reg_wdata == OPC_READ48);
	assign is_rdq  = (reg_wdata == OPC_READ_Q);

	// start count per command form
	always_comb begin
		cnt_start = {9'h000, scnt_ff.cur};
		if (is_rd28) begin
			if (scnt_ff.cur == RST_BYTE) begin
				cnt_start = CNT28_MAX;
			end
		end else if (is_rdq) begin
			cnt_start = {1'b0, feat_ff.prv, feat_ff.cur};
			if (cnt_start == 17'h00000) begin
				cnt_start = CNT48_MAX;
			end
		end else begin
			cnt_start = {1'b0, scnt_ff.prv, scnt_ff.cur};
			if (cnt_start == 17'h00000) begin
				cnt_start = CNT48_MAX;
			end
		end
	end

	// start address per command form
	always_comb begin
		if (is_rd28) begin
			// head nibble doubles as LBA 27:24
			addr_start = {20'h00000, devhead_ff[3:0], cylhi_ff.cur, cyllo_ff.cur, snum_ff.cur};
		end else begin
			// previous bytes form the upper half
			addr_start = {cylhi_ff.prv, cyllo_ff.prv, snum_ff.prv, cylhi_ff.cur, cyllo_ff.cur, snum_ff.cur};
		end
	end

	// a word is moved only when the request is up and host acknowledges
	assign take_word = full_ff && dma_ack;
	assign sec_done  = (state_ff == ST_XFER) && take_word && lastw_ff;
	assign med_fail  = (state_ff == ST_XFER) && (med_unc || med_idnf);
	assign fail_any  = med_fail || ((state_ff == ST_XFER) && crc_err);

	// sequencing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cmd_wr) begin
					nxt_state = (is_rd28 || is_rd48 || is_rdq) ? ST_SEEK : ST_DONE;
				end
			end
			ST_SEEK: begin
				nxt_state = ST_XFER;
			end
			ST_XFER: begin
				if (fail_any) begin
					nxt_state = ST_DONE;
				end else if (sec_done) begin
					nxt_state = (remain_ff == 17'h00001) ? ST_DONE : ST_SEEK;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// command context, address and count
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_ff    <= 1'b0;
			chs_ff    <= 1'b0;
			addr_ff   <= 48'h0;
			last_ff   <= 48'h0;
			remain_ff <= 17'h0;
		end else if (state_ff == ST_IDLE && cmd_wr) begin
			ext_ff    <= !is_rd28;
			// addressing mode latched at command write
			chs_ff    <= is_rd28 && !devhead_ff[DH_LBA_BIT];
			addr_ff   <= addr_start;
			last_ff   <= addr_start;
			remain_ff <= cnt_start;
		end else if (sec_done && !fail_any) begin
			last_ff   <= addr_ff;
			addr_ff   <= next_addr(addr_ff, chs_ff);
			remain_ff <= remain_ff - 17'h1;
		end
	end

	// error flags, cleared at each new command
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			err_ff <= RST_BYTE;
		end else if (state_ff == ST_IDLE && cmd_wr) begin
			err_ff <= RST_BYTE;
			if (!(is_rd28 || is_rd48 || is_rdq)) begin
				err_ff[ERR_ABT_BIT] <= 1'b1;
			end
		end else if (state_ff == ST_XFER) begin
			// only bits 7, 6 and 4 can be set here
			if (crc_err) begin
				err_ff[ERR_CRC_BIT] <= 1'b1;
			end
			if (med_unc) begin
				err_ff[ERR_UNC_BIT] <= 1'b1;
			end
			if (med_idnf) begin
				err_ff[ERR_IDN_BIT] <= 1'b1;
			end
		end
	end

	// one word holding stage between media and host
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			word_ff  <= 16'h0;
			full_ff  <= 1'b0;
			lastw_ff <= 1'b0;
		end else if (state_ff != ST_XFER || fail_any) begin
			full_ff  <= 1'b0;
			lastw_ff <= 1'b0;
		end else if (med_valid && med_ready) begin
			word_ff  <= med_data;
			full_ff  <= 1'b1;
			lastw_ff <= med_last;
		end else if (take_word) begin
			full_ff  <= 1'b0;
		end
	end

	assign med_ready   = (state_ff == ST_XFER) && !full_ff;
	assign med_req     = (state_ff == ST_SEEK);
	assign med_cmd     = '{addr: addr_ff, chs: chs_ff};
	assign dmarq       = full_ff;
	assign dma_data    = word_ff;

	// address reported at completion: failing sector on error, else last done
	assign rep_addr = (err_ff[ERR_UNC_BIT] || err_ff[ERR_IDN_BIT] || err_ff[ERR_CRC_BIT]) ? addr_ff : last_ff;

	// command block bytes; written by the host while idle, loaded with results at done
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			feat_ff    <= '{prv: RST_BYTE, cur: RST_BYTE};
			scnt_ff    <= '{prv: RST_BYTE, cur: RST_BYTE};
			snum_ff    <= '{prv: RST_BYTE, cur: RST_BYTE};
			cyllo_ff   <= '{prv: RST_BYTE, cur: RST_BYTE};
			cylhi_ff   <= '{prv: RST_BYTE, cur: RST_BYTE};
			devhead_ff <= RST_BYTE;
		end else if (state_ff == ST_DONE && !err_ff[ERR_ABT_BIT]) begin
			scnt_ff    <= '{prv: remain_ff[15:8], cur: remain_ff[7:0]};
			// last sector address in the address bytes
			// upper three bytes held in the previous half
			snum_ff    <= '{prv: rep_addr[31:24], cur: rep_addr[7:0]};
			cyllo_ff   <= '{prv: rep_addr[39:32], cur: rep_addr[15:8]};
			cylhi_ff   <= '{prv: rep_addr[47:40], cur: rep_addr[23:16]};
			if (!ext_ff) begin
				devhead_ff[3:0] <= rep_addr[27:24];
			end
		end else if (reg_wr && !busy) begin
			if (reg_addr == ADR_FEATURE) begin
				feat_ff <= '{prv: feat_ff.cur, cur: reg_wdata};
			end else if (reg_addr == ADR_SECCNT) begin
				scnt_ff <= '{prv: scnt_ff.cur, cur: reg_wdata};
			end else if (reg_addr == ADR_SECNUM) begin
				snum_ff <= '{prv: snum_ff.cur, cur: reg_wdata};
			end else if (reg_addr == ADR_CYLLO) begin
				cyllo_ff <= '{prv: cyllo_ff.cur, cur: reg_wdata};
			end else if (reg_addr == ADR_CYLHI) begin
				cylhi_ff <= '{prv: cylhi_ff.cur, cur: reg_wdata};
			end else if (reg_addr == ADR_DEVHEAD) begin
				devhead_ff <= reg_wdata;
			end
		end
	end

	// high-order byte select
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hob_ff <= 1'b0;
		end else if (reg_wr && reg_addr == ADR_DEVCTL) begin
			hob_ff <= reg_wdata[CTL_HOB_BIT];
		end else if (reg_wr && reg_addr != ADR_INT_STAT && reg_addr != ADR_INT_MASK && !busy) begin
			hob_ff <= 1'b0;
		end
	end

	// done event, and fail event on any error, raised only in the done state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			int_stat_ff <= RST_INT;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (state_ff == ST_DONE && (i == INT_DONE_BIT || err_ff != RST_BYTE)) begin
					int_stat_ff[i] <= 1'b1;
				end else if (reg_wr && reg_addr == ADR_INT_STAT && reg_wdata[i]) begin
					int_stat_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			int_mask_ff <= RST_INT;
		end else if (reg_wr && reg_addr == ADR_INT_MASK) begin
			int_mask_ff <= reg_wdata[1:0];
		end
	end

	assign irq = |(int_stat_ff & int_mask_ff);

	// busy, fault, corrected clear once done; ready and seek complete set
	always_comb begin
		status              = RST_BYTE;
		status[ST_BSY_BIT]  = busy;
		status[ST_RDY_BIT]  = !busy;
		status[ST_DSC_BIT]  = !busy;
		status[ST_DRQ_BIT]  = full_ff;
		status[ST_ERR_BIT]  = !busy && (err_ff != RST_BYTE);
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst || !reg_rd) begin
			rdata_ff <= RST_BYTE;
		end else if (reg_addr == ADR_FEATURE) begin
			rdata_ff <= hob_ff ? feat_ff.prv : feat_ff.cur;
		end else if (reg_addr == ADR_SECCNT) begin
			rdata_ff <= hob_ff ? scnt_ff.prv : scnt_ff.cur;
		end else if (reg_addr == ADR_SECNUM) begin
			rdata_ff <= hob_ff ? snum_ff.prv : snum_ff.cur;
		end else if (reg_addr == ADR_CYLLO) begin
			rdata_ff <= hob_ff ? cyllo_ff.prv : cyllo_ff.cur;
		end else if (reg_addr == ADR_CYLHI) begin
			rdata_ff <= hob_ff ? cylhi_ff.prv : cylhi_ff.cur;
		end else if (reg_addr == ADR_DEVHEAD) begin
			rdata_ff <= devhead_ff;
		end else if (reg_addr == ADR_CMD_STAT) begin
			rdata_ff <= status;
		end else if (reg_addr == ADR_ERROR) begin
			rdata_ff <= err_ff;
		end else if (reg_addr == ADR_DEVCTL) begin
			rdata_ff <= {hob_ff, 7'h00};
		end else if (reg_addr == ADR_INT_STAT) begin
			rdata_ff <= {6'h00, int_stat_ff};
		end else if (reg_addr == ADR_INT_MASK) begin
			rdata_ff <= {6'h00, int_mask_ff};
		end else begin
			rdata_ff <= RST_BYTE;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

// ==== rdcmd_far_model.sv ====
// media engine and host dma channel model on the far side of the decoder
`timescale 1ns/10ps
`default_nettype none
module rdcmd_far_model
	import rdcmd_pkg::*;
#(
	parameter int WORDS_PER_SEC = 2
) (
	// clock, reset and scenario control
	input wire logic                    mclk,
	input wire logic                    sys_rst,
	input wire logic                    clr,
	input wire logic                    slow,
	input wire logic                    fail_en,
	input wire logic [7:0]              fail_at,
	input wire logic [1:0]              fail_kind,
	// media engine
	input wire logic                    med_req,
	input wire rdcmd_pkg::med_req_type  med_cmd,
	input wire logic                    med_ready,
	output logic                        med_valid,
	output logic [15:0]                 med_data,
	output logic                        med_last,
	output logic                        med_unc,
	output logic                        med_idnf,
	// host dma
	input wire logic                    dmarq,
	input wire logic [15:0]             dma_data,
	output logic                        dma_ack,
	output logic                        crc_err,
	// observation
	output logic [15:0]                 secs_ff,
	output logic [15:0]                 words_ff,
	output logic [7:0]                  bad_ff,
	output rdcmd_pkg::med_req_type      first_ff
);
	import rdcmd_pkg::*;
	logic        active_ff;
	logic        fault_ff;
	logic        ph_ff;
	logic [15:0] wi_ff;
	logic [15:0] mw_ff;
	assign med_valid = active_ff && !fault_ff;
	// idle data lines show the inverse so stale words never pass
	assign med_data  = med_valid ? mw_ff : ~mw_ff;
	assign med_last  = med_valid && (wi_ff == 16'(WORDS_PER_SEC - 1));
	assign med_unc   = fault_ff && (fail_kind == 2'h0);
	assign med_idnf  = fault_ff && (fail_kind == 2'h1);
	assign crc_err   = fault_ff && (fail_kind == 2'h2);
	// channel armed from reset, takes words only on request
	assign dma_ack   = dmarq && (!slow || ph_ff);
	always_ff @(posedge mclk) begin
		if (sys_rst || clr) begin
			active_ff <= 1'b0;
			fault_ff  <= 1'b0;
			wi_ff     <= 16'h0;
			mw_ff     <= 16'h0;
			secs_ff   <= 16'h0;
			first_ff  <= '0;
		end else if (med_req) begin
			active_ff <= 1'b1;
			wi_ff     <= 16'h0;
			secs_ff   <= secs_ff + 16'h1;
			fault_ff  <= fail_en && (secs_ff == {8'h00, fail_at});
			if (secs_ff == 16'h0) begin
				first_ff <= med_cmd;
			end
		end else begin
			fault_ff <= 1'b0;
			if (med_valid && med_ready) begin
				mw_ff     <= mw_ff + 16'h1;
				wi_ff     <= wi_ff + 16'h1;
				active_ff <= !med_last;
			end
		end
	end
	always_ff @(posedge mclk) begin
		ph_ff <= !ph_ff && !sys_rst;
		if (sys_rst || clr) begin
			words_ff <= 16'h0;
		end else if (dmarq && dma_ack) begin
			words_ff <= words_ff + 16'h1;
		end
		if (sys_rst) begin
			bad_ff <= 8'h00;
		end else if (dmarq && dma_ack && !clr && dma_data !== words_ff) begin
			bad_ff <= bad_ff + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== rdcmd_monitor.sv ====
// assertion checker for the dma read command decoder, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module rdcmd_monitor
	import rdcmd_pkg::*;
#(
	parameter int         WORDS_PER_SEC = 256,
	parameter logic [7:0] CHS_SPT       = 8'h3f,
	parameter logic [3:0] CHS_HEADS     = 4'hf
) (
	// clock and reset
	input wire logic                   mclk,
	input wire logic                   sys_rst,
	// media engine
	input wire logic                   med_req,
	input wire rdcmd_pkg::med_req_type med_cmd,
	input wire logic                   med_valid,
	input wire logic                   med_ready,
	input wire logic [15:0]            med_data,
	input wire logic                   med_unc,
	input wire logic                   med_idnf,
	// host dma and interrupt
	input wire logic                   dmarq,
	input wire logic                   dma_ack,
	input wire logic [15:0]            dma_data,
	input wire logic                   crc_err,
	input wire logic                   irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence word_in;
		med_valid && med_ready;
	endsequence
	sequence word_out;
		dmarq && dma_ack;
	endsequence
	sequence fault_seen;
		(med_unc || med_idnf || crc_err) && med_ready;
	endsequence
	a_dmarq_wait: assert property (dmarq && !dma_ack |=> dmarq && $stable(dma_data))
		else $error("dma request or word changed before the host took it");
	a_dmarq_drop: assert property (word_out |=> !dmarq)
		else $error("dma request stayed up after the host took the word");
	a_word_pass: assert property (word_in |=> dmarq && dma_data == $past(med_data))
		else $error("media word not offered to the host next cycle");
	a_one_word: assert property (dmarq |-> !med_ready)
		else $error("media accepted a word while one is waiting");
	a_seek_step: assert property (med_req |=> !med_req && med_ready)
		else $error("sector request not followed by transfer");
	a_fault_stop: assert property (fault_seen |=> (!med_req && !med_ready) [*2])
		else $error("transfer went on after a media or link fault");
	a_irq_after: assert property ($rose(irq) |-> !dmarq && !med_ready && !med_req)
		else $error("interrupt raised while the transfer was still running");
	a_chs_range: assert property (med_req && med_cmd.chs |-> med_cmd.addr[7:0] inside {[1:CHS_SPT]}
		&& med_cmd.addr[27:24] <= CHS_HEADS && med_cmd.addr[47:28] == '0)
		else $error("chs sector request out of geometry");
endmodule
bind dma_read_cmd rdcmd_monitor #(
	.WORDS_PER_SEC(WORDS_PER_SEC),
	.CHS_SPT      (CHS_SPT),
	.CHS_HEADS    (CHS_HEADS)
) u_monitor (
	.mclk     (mclk),
	.sys_rst  (sys_rst),
	.med_req  (med_req),
	.med_cmd  (med_cmd),
	.med_valid(med_valid),
	.med_ready(med_ready),
	.med_data (med_data),
	.med_unc  (med_unc),
	.med_idnf (med_idnf),
	.dmarq    (dmarq),
	.dma_ack  (dma_ack),
	.dma_data (dma_data),
	.crc_err  (crc_err),
	.irq      (irq)
);
`default_nettype wire

// ==== rdcmd_pkg.sv ====
// constants, field layouts and carrier types for the dma read command decoder
package rdcmd_pkg;

	// register index map on the local register port
	localparam logic [3:0] ADR_FEATURE   = 4'h1;
	localparam logic [3:0] ADR_SECCNT    = 4'h2;
	localparam logic [3:0] ADR_SECNUM    = 4'h3;
	localparam logic [3:0] ADR_CYLLO     = 4'h4;
	localparam logic [3:0] ADR_CYLHI     = 4'h5;
	localparam logic [3:0] ADR_DEVHEAD   = 4'h6;
	localparam logic [3:0] ADR_CMD_STAT  = 4'h7;
	localparam logic [3:0] ADR_ERROR     = 4'h8;
	localparam logic [3:0] ADR_DEVCTL    = 4'h9;
	localparam logic [3:0] ADR_INT_STAT  = 4'ha;
	localparam logic [3:0] ADR_INT_MASK  = 4'hb;

	// opcodes; the 28-bit read is matched on bits 7:1 only
	localparam logic [6:0] OPC_READ28_HI = 7'h64;
	localparam logic [7:0] OPC_READ48    = 8'h25;
	localparam logic [7:0] OPC_READ_Q    = 8'h60;

	// field positions
	localparam int DH_LBA_BIT   = 6;
	localparam int CTL_HOB_BIT  = 7;
	localparam int ERR_CRC_BIT  = 7;
	localparam int ERR_UNC_BIT  = 6;
	localparam int ERR_IDN_BIT  = 4;
	localparam int ERR_ABT_BIT  = 2;
	localparam int ST_BSY_BIT   = 7;
	localparam int ST_RDY_BIT   = 6;
	localparam int ST_DSC_BIT   = 4;
	localparam int ST_DRQ_BIT   = 3;
	localparam int ST_ERR_BIT   = 0;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_FAIL_BIT = 1;

	// sector counts given by a zero count field
	localparam logic [16:0] CNT28_MAX = 17'h00100;
	localparam logic [16:0] CNT48_MAX = 17'h10000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [1:0]  RST_INT   = 2'h0;
	localparam logic [7:0]  FIRST_SEC = 8'h01;

	// command block byte with its previously written value
	typedef struct packed {
		logic [7:0] prv;
		logic [7:0] cur;
	} tf_pair_type;

	// sector request toward the media engine
	typedef struct packed {
		logic [47:0] addr;
		logic        chs;
	} med_req_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEEK = 2'b01,
		ST_XFER = 2'b10,
		ST_DONE = 2'b11
	} state_type;

endpackage

// ==== test_dma_read_cmd.sv ====
// self-checking testbench for the dma read command decoder
`timescale 1ns/10ps
`default_nettype none
module test_dma_read_cmd;
	import rdcmd_pkg::*;
	localparam int WPS = 2;
	logic        mclk = 1'b0;
	logic        sys_rst, reg_wr, reg_rd, clr, slow, fail_en;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, fail_at, bad;
	logic [1:0]  fail_kind;
	logic        med_req, med_valid, med_ready, med_last, med_unc, med_idnf;
	logic        dmarq, dma_ack, crc_err, irq, irq_q = 1'b0;
	logic [15:0] med_data, dma_data, secs, words;
	med_req_type med_cmd, first;
	int          errors = 0;
	int          tests_run = 0;
	int          irqs = 0;
	int          k;
	always #20 mclk = ~mclk;
	dma_read_cmd #(.WORDS_PER_SEC(WPS)) uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .med_req(med_req),
		.med_cmd(med_cmd), .med_valid(med_valid), .med_ready(med_ready), .med_data(med_data), .med_last(med_last),
		.med_unc(med_unc), .med_idnf(med_idnf), .dmarq(dmarq), .dma_ack(dma_ack), .dma_data(dma_data),
		.crc_err(crc_err), .irq(irq));
	rdcmd_far_model #(.WORDS_PER_SEC(WPS)) far (.mclk(mclk), .sys_rst(sys_rst), .clr(clr), .slow(slow),
		.fail_en(fail_en), .fail_at(fail_at), .fail_kind(fail_kind), .med_req(med_req), .med_cmd(med_cmd),
		.med_ready(med_ready), .med_valid(med_valid), .med_data(med_data), .med_last(med_last),
		.med_unc(med_unc), .med_idnf(med_idnf), .dmarq(dmarq), .dma_data(dma_data), .dma_ack(dma_ack),
		.crc_err(crc_err), .secs_ff(secs), .words_ff(words), .bad_ff(bad), .first_ff(first));
	always @(posedge mclk) begin
		irq_q <= irq;
		if (irq === 1'b1 && irq_q === 1'b0) irqs++;
	end
	task conclude;
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task rchk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	task rd3(input logic [23:0] e);
		rchk(ADR_SECNUM, e[7:0]);
		rchk(ADR_CYLLO, e[15:8]);
		rchk(ADR_CYLHI, e[23:16]);
	endtask
	// previous bytes first, then current, then the opcode; waits out busy
	task issue(input logic [7:0] op, input logic [47:0] la, input logic [15:0] n, input logic [7:0] dh);
		logic [7:0] v;
		int i;
		for (i = 0; i < 2; i++) begin
			wr(ADR_FEATURE, i ? n[7:0] : n[15:8]);
			wr(ADR_SECCNT, i ? n[7:0] : n[15:8]);
			wr(ADR_SECNUM, i ? la[7:0] : la[31:24]);
			wr(ADR_CYLLO, i ? la[15:8] : la[39:32]);
			wr(ADR_CYLHI, i ? la[23:16] : la[47:40]);
		end
		wr(ADR_DEVHEAD, dh);
		clr <= 1'b1;
		irqs = 0;
		wr(ADR_CMD_STAT, op);
		clr <= 1'b0;
		v = 8'h80;
		for (i = 0; i < 4000 && v[ST_BSY_BIT] !== 1'b0; i++) rd(ADR_CMD_STAT, v);
		if (v[ST_BSY_BIT] !== 1'b0) begin
			errors++;
			$display("[FAIL] %0t command never finished", $time);
			conclude();
		end
	endtask
	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		$display("[FAIL] %0t run too long", $time);
		conclude();
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, clr, slow, fail_en} = 6'h20;
		{reg_addr, reg_wdata, fail_at, fail_kind} = '0;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		rchk(ADR_CMD_STAT, 8'h50);
		rchk(ADR_ERROR, 8'h00);
		rchk(4'hc, 8'h00);
		wr(ADR_INT_MASK, 8'h03);
		issue(8'hc9, 48'h0a123456, 16'h0002, 8'h4a);
		chk(first.addr, 48'h0a123456);
		chk(secs, 2);
		chk(words, 2 * WPS);
		rchk(ADR_SECCNT, 8'h00);
		rd3(24'h123457);
		rchk(ADR_DEVHEAD, 8'h4a);
		rchk(ADR_CMD_STAT, 8'h50);
		chk(irqs, 1);
		wr(ADR_INT_STAT, 8'h01);
		rchk(ADR_INT_STAT, 8'h00);
		chk(irq, 0);
		// chs read of a zero count with a stalling host and the interrupt masked
		wr(ADR_INT_MASK, 8'h00);
		slow <= 1'b1;
		issue(8'hc8, 48'h010201, 16'h0000, 8'h03);
		chk(first.chs, 1);
		chk(first.addr, 48'h3010201);
		chk(secs, 256);
		chk(words, 256 * WPS);
		rchk(ADR_SECCNT, 8'h00);
		rd3(24'h010204);
		rchk(ADR_DEVHEAD, 8'h07);
		chk(irqs, 0);
		wr(ADR_INT_MASK, 8'h03);
		rchk(ADR_INT_STAT, 8'h01);
		chk(irq, 1);
		wr(ADR_INT_STAT, 8'h01);
		slow <= 1'b0;
		issue(OPC_READ48, 48'h654321abcdef, 16'h0102, 8'h40);
		chk(first.addr, 48'h654321abcdef);
		chk(secs, 258);
		chk(words, 258 * WPS);
		rd3(24'habcef0);
		wr(ADR_DEVCTL, 8'h80);
		rd3(24'h654321);
		wr(ADR_DEVCTL, 8'h00);
		wr(ADR_INT_STAT, 8'h01);
		// zero counts failing on sectors 0, 1 and 2 by media, id and link faults
		for (k = 0; k < 3; k++) begin
			fail_en <= 1'b1;
			fail_at <= 8'(k);
			fail_kind <= 2'(k);
			issue(k == 1 ? OPC_READ_Q : OPC_READ48, 48'h1000, 16'h0000, 8'h40);
			chk(secs, k + 1);
			chk(words, k * WPS);
			chk(irqs, 1);
			rchk(ADR_ERROR, {k == 2, k == 0, 1'b0, k == 1, 4'h0});
			rchk(ADR_CMD_STAT, 8'h51);
			rchk(ADR_SECCNT, 8'(-k));
			rd3(24'h001000 + 24'(k));
			wr(ADR_DEVCTL, 8'h80);
			rchk(ADR_SECCNT, k ? 8'hff : 8'h00);
			rd3(24'h000000);
			wr(ADR_DEVCTL, 8'h00);
			wr(ADR_INT_STAT, 8'h03);
		end
		fail_en <= 1'b0;
		issue(8'h00, 48'h1000, 16'h0001, 8'h40);
		rchk(ADR_ERROR, 8'h04);
		chk(secs, 0);
		rchk(ADR_INT_STAT, 8'h03);
		chk(irqs, 1);
		chk(bad, 0);
		conclude();
	end
endmodule
`default_nettype wire
